// *** ccpm_pkg.sv ***
`default_nettype none
package ccpm_pkg;
	// Register byte addresses on the APB window.
	localparam int         ADDR_W    = 8;
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_DUTYH = 8'h04;
	localparam logic [7:0] OFS_CAPT  = 8'h08;
	localparam logic [7:0] OFS_STAT  = 8'h0c;
	localparam logic [7:0] OFS_CLR   = 8'h10;
	localparam logic [7:0] OFS_IEN   = 8'h14;
	// Field positions in the unit control register.
	localparam int CFG_MSB  = 7;
	localparam int CFG_LSB  = 6;
	localparam int DLB_MSB  = 5;
	localparam int DLB_LSB  = 4;
	localparam int MODE_MSB = 3;
	localparam int POL_A    = 1;
	localparam int POL_B    = 0;
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [7:0] DUTYH_RST = 8'h00;
	// Unit mode codes.
	localparam logic [3:0] MODE_OFF      = 4'h0;
	localparam logic [3:0] MODE_TOGGLE   = 4'h2;
	localparam logic [3:0] MODE_CAP_FALL = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE = 4'h5;
	localparam logic [3:0] MODE_CAP_4    = 4'h6;
	localparam logic [3:0] MODE_CAP_16   = 4'h7;
	localparam logic [3:0] MODE_CMP_SET  = 4'h8;
	localparam logic [3:0] MODE_CMP_CLR  = 4'h9;
	localparam logic [3:0] MODE_CMP_INT  = 4'ha;
	localparam logic [3:0] MODE_SPECIAL  = 4'hb;
	localparam logic [1:0] MODE_PWM_HI   = 2'b11;
	localparam logic [1:0] CFG_HALF      = 2'b10;
	// Capture prescaler terminal counts.
	localparam logic [3:0] CAP4_LAST  = 4'h3;
	localparam logic [3:0] CAP16_LAST = 4'hf;
	localparam logic [3:0] CNT_ZERO   = 4'h0;
	// Interrupt status bits.
	localparam int INT_W     = 2;
	localparam int INT_EVENT = 0;
	localparam int INT_TRIG  = 1;
	localparam int PWM_W     = 10;
endpackage : ccpm_pkg
`default_nettype wire

// *** ccpm_edge_if.sv ***
`default_nettype none
interface ccpm_edge_if;
	logic rise;
	logic fall;
	modport src (output rise, output fall);
	modport snk (input rise, input fall);
endinterface : ccpm_edge_if
`default_nettype wire

// *** ccpm_edge.sv ***
`default_nettype none
module ccpm_edge
	import ccpm_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	input  wire logic pin,
	ccpm_edge_if.src  edg
);
	logic sync1_r, sync2_r, prev_r;
	logic sync1_nxt, sync2_nxt, prev_nxt;

	// Two flops tame the asynchronous pin; only the second is looked at.
	always_comb begin
		sync1_nxt = pin;
		sync2_nxt = sync1_r;
		prev_nxt  = sync2_r;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r  <= 1'b0;
		end else if (ce) begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r  <= prev_nxt;
		end
	end

	// Edge pulses last one enabled cycle.
	assign edg.rise = sync2_r & ~prev_r;
	assign edg.fall = ~sync2_r & prev_r;
endmodule : ccpm_edge
`default_nettype wire

// *** ccpm_unit.sv ***
// What this block does
// - Config 10 in PWM: complementary half-bridge pair.
// - Config 00 in PWM: first output only.
// - Non-PWM modes: first pin CCP, second port.
// - PWM duty is high register plus bits 5:4.
// - Mode 1011 match resets timer, sets flag.
// - Mode 1011 match starts ADC if enabled.
// - Mode 0000 turns unit off, held reset.
// - 0101 captures rising edges, 0100 falling edges.
// - Mode 0010 toggles compare output on match.
//
// Chosen here: register access over APB and the placing of the registers.
`default_nettype none
module ccpm_unit
	import ccpm_pkg::*;
#(
	parameter int TMR_W = 16
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire logic              cap_pin,
	input  wire logic [TMR_W-1:0]  timer_value,
	input  wire logic [PWM_W-1:0]  pwm_count,
	input  wire logic              compare_match,
	input  wire logic              adc_enabled,
	output var  logic              timer_reset,
	output var  logic              adc_start,
	output var  logic              out_first,
	output var  logic              oe_first,
	output var  logic              out_second,
	output var  logic              oe_second,
	output var  logic              irq
);
	// The capture value must fit the read word and stay wide enough to matter.
	if (TMR_W < 8 || TMR_W > 32) begin : g_bad_tmr_w
		$error("ccpm_unit: TMR_W must lie between 8 and 32");
	end

	ccpm_edge_if edg ();

	ccpm_edge ccpm_edge_inst (
		.clk (clk),
		.rst (rst),
		.ce  (ce),
		.pin (cap_pin),
		.edg (edg.src)
	);

	////////////////////////////////////////////////////////////////////////////
	logic [7:0]       ctrl_r, ctrl_nxt, dutyh_r, dutyh_nxt;
	logic [TMR_W-1:0] capt_r, capt_nxt;
	logic [INT_W-1:0] stat_r, stat_nxt, ien_r, ien_nxt;
	logic [31:0]      prdata_r, prdata_nxt;
	logic             err_r, err_nxt;
	logic [3:0]       mode_prev_r, mode_prev_nxt, cap_cnt_r, cap_cnt_nxt;
	logic             cmp_out_r, cmp_out_nxt;
	logic             out_first_r, out_first_nxt, oe_first_r, oe_first_nxt;
	logic             out_second_r, out_second_nxt, oe_second_r, oe_second_nxt;
	logic             timer_reset_r, timer_reset_nxt, adc_start_r, adc_start_nxt;
	logic [3:0]       mode;
	logic [1:0]       cfg;
	logic             pwm_mode, pwm_raw, wr, setup;
	logic             cap_hit, cmp_hit, special_hit;
	logic [PWM_W-1:0] duty;

	assign mode     = ctrl_r[MODE_MSB:0];
	assign cfg      = ctrl_r[CFG_MSB:CFG_LSB];
	assign pwm_mode = (mode[MODE_MSB:2] == MODE_PWM_HI);
	assign duty     = {dutyh_r, ctrl_r[DLB_MSB:DLB_LSB]};
	assign pwm_raw  = (pwm_count < duty);
	assign wr       = psel & penable & pwrite;
	assign setup    = psel & ~penable;

	////////////////////////////////////////////////////////////////////////////
	// Capture and compare events. A capture in a mode whose prescaler has not
	// reached its terminal count only advances the count.
	always_comb begin
		cap_hit     = 1'b0;
		cap_cnt_nxt = cap_cnt_r;
		unique case (mode)
			MODE_CAP_RISE: cap_hit = edg.rise;
			MODE_CAP_FALL: cap_hit = edg.fall;
			MODE_CAP_4, MODE_CAP_16: begin
				if (edg.rise) begin
					if (cap_cnt_r == ((mode == MODE_CAP_4) ? CAP4_LAST : CAP16_LAST)) begin
						cap_hit     = 1'b1;
						cap_cnt_nxt = CNT_ZERO;
					end else begin
						cap_cnt_nxt = cap_cnt_r + 4'h1;
					end
				end
			end
			default: cap_hit = 1'b0;
		endcase
		// A mode change restarts the prescaler; mode off holds it cleared.
		if (mode != mode_prev_r || mode == MODE_OFF) begin
			cap_cnt_nxt = CNT_ZERO;
		end
		cmp_hit = compare_match && (mode == MODE_TOGGLE || mode == MODE_CMP_SET ||
			mode == MODE_CMP_CLR || mode == MODE_CMP_INT || mode == MODE_SPECIAL);
		special_hit = compare_match && (mode == MODE_SPECIAL);
		capt_nxt    = cap_hit ? timer_value : capt_r;
		mode_prev_nxt = mode;
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare output latch. Entering a compare mode sets its starting level.
	always_comb begin
		cmp_out_nxt = cmp_out_r;
		if (mode != mode_prev_r) begin
			cmp_out_nxt = (mode == MODE_CMP_CLR);
		end else if (compare_match) begin
			unique case (mode)
				MODE_TOGGLE:  cmp_out_nxt = ~cmp_out_r;
				MODE_CMP_SET: cmp_out_nxt = 1'b1;
				MODE_CMP_CLR: cmp_out_nxt = 1'b0;
				default:      cmp_out_nxt = cmp_out_r;
			endcase
		end
		if (mode == MODE_OFF) begin
			cmp_out_nxt = 1'b0;
		end
		timer_reset_nxt = special_hit;
		adc_start_nxt   = special_hit & adc_enabled;
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin steering. The dead band is added downstream, so the pair here is a
	// plain complement; reserved configurations fall back to a single output.
	always_comb begin
		out_second_nxt = 1'b0;
		oe_second_nxt  = 1'b0;
		if (pwm_mode) begin
			out_first_nxt = pwm_raw ^ mode[POL_A];
			oe_first_nxt  = 1'b1;
			if (cfg == CFG_HALF) begin
				out_second_nxt = ~pwm_raw ^ mode[POL_B];
				oe_second_nxt  = 1'b1;
			end
		end else begin
			out_first_nxt = cmp_out_nxt;
			oe_first_nxt  = (mode == MODE_TOGGLE || mode == MODE_CMP_SET ||
				mode == MODE_CMP_CLR || mode == MODE_SPECIAL);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data latched in the setup cycle.
	always_comb begin
		ctrl_nxt  = ctrl_r;
		dutyh_nxt = dutyh_r;
		ien_nxt   = ien_r;
		if (wr && paddr == OFS_CTRL) begin
			ctrl_nxt = pwdata[7:0];
		end
		if (wr && paddr == OFS_DUTYH) begin
			dutyh_nxt = pwdata[7:0];
		end
		if (wr && paddr == OFS_IEN) begin
			ien_nxt = pwdata[INT_W-1:0];
		end
		// Hardware set beats a same-cycle software clear.
		stat_nxt = stat_r;
		if (wr && paddr == OFS_CLR) begin
			stat_nxt = stat_r & ~pwdata[INT_W-1:0];
		end
		stat_nxt[INT_EVENT] = stat_nxt[INT_EVENT] | cap_hit | cmp_hit;
		stat_nxt[INT_TRIG]  = stat_nxt[INT_TRIG] | special_hit;
		prdata_nxt = prdata_r;
		err_nxt    = err_r;
		if (setup) begin
			prdata_nxt = 32'h0000_0000;
			err_nxt    = 1'b0;
			unique case (paddr)
				OFS_CTRL:  prdata_nxt[7:0] = ctrl_r;
				OFS_DUTYH: prdata_nxt[7:0] = dutyh_r;
				OFS_CAPT:  prdata_nxt[TMR_W-1:0] = capt_r;
				OFS_STAT:  prdata_nxt[INT_W-1:0] = stat_r;
				OFS_IEN:   prdata_nxt[INT_W-1:0] = ien_r;
				OFS_CLR:   prdata_nxt = 32'h0000_0000;
				default:   err_nxt = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_r        <= CTRL_RST;
			dutyh_r       <= DUTYH_RST;
			ien_r         <= '0;
			stat_r        <= '0;
			capt_r        <= '0;
			prdata_r      <= 32'h0000_0000;
			err_r         <= 1'b0;
			mode_prev_r   <= MODE_OFF;
			cap_cnt_r     <= CNT_ZERO;
			cmp_out_r     <= 1'b0;
			out_first_r   <= 1'b0;
			oe_first_r    <= 1'b0;
			out_second_r  <= 1'b0;
			oe_second_r   <= 1'b0;
			timer_reset_r <= 1'b0;
			adc_start_r   <= 1'b0;
		end else if (ce) begin
			ctrl_r        <= ctrl_nxt;
			dutyh_r       <= dutyh_nxt;
			ien_r         <= ien_nxt;
			stat_r        <= stat_nxt;
			capt_r        <= capt_nxt;
			prdata_r      <= prdata_nxt;
			err_r         <= err_nxt;
			mode_prev_r   <= mode_prev_nxt;
			cap_cnt_r     <= cap_cnt_nxt;
			cmp_out_r     <= cmp_out_nxt;
			out_first_r   <= out_first_nxt;
			oe_first_r    <= oe_first_nxt;
			out_second_r  <= out_second_nxt;
			oe_second_r   <= oe_second_nxt;
			timer_reset_r <= timer_reset_nxt;
			adc_start_r   <= adc_start_nxt;
		end
	end

	// pready follows ce, so a frozen clock enable hangs the bus.
	assign pready      = ce;
	assign pslverr     = err_r & psel & penable;
	assign prdata      = prdata_r;
	assign timer_reset = timer_reset_r;
	assign adc_start   = adc_start_r;
	assign out_first   = out_first_r;
	assign oe_first    = oe_first_r;
	assign out_second  = out_second_r;
	assign oe_second   = oe_second_r;
	assign irq         = |(stat_r & ien_r);

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_HALF_PAIR: assert property (ce && pwm_mode && cfg == CFG_HALF |=> oe_second_r &&
		((out_second_r ^ $past(mode[POL_B])) != (out_first_r ^ $past(mode[POL_A]))))
		else $error("half-bridge pair not complementary");
	AST_SINGLE: assert property (ce && pwm_mode && cfg != CFG_HALF |=>
		oe_first_r && !oe_second_r) else $error("single output steering wrong");
	AST_NONPWM: assert property (ce && !pwm_mode |=> !oe_second_r)
		else $error("second pin driven outside PWM");
	AST_DUTY: assert property (ce && pwm_mode |=> oe_first_r &&
		((out_first_r ^ $past(mode[POL_A])) == ($past(pwm_count) < $past(duty))))
		else $error("PWM level does not follow duty");
	AST_SPECIAL: assert property (ce && special_hit |=> timer_reset_r &&
		stat_r[INT_EVENT] && stat_r[INT_TRIG]) else $error("special trigger missed");
	AST_ADC: assert property (ce && special_hit |=> adc_start_r == $past(adc_enabled))
		else $error("ADC start wrong");
	AST_CTRL_WR: assert property (ce && wr && paddr == OFS_CTRL |=>
		ctrl_r == $past(pwdata[7:0])) else $error("control write lost");
	AST_OFF: assert property (ce && mode == MODE_OFF |=> !oe_first_r &&
		!oe_second_r && cap_cnt_r == CNT_ZERO && !cmp_out_r) else $error("off mode not idle");
	AST_CAP: assert property (ce && mode == MODE_CAP_RISE && edg.rise |=>
		capt_r == $past(timer_value) && stat_r[INT_EVENT]) else $error("capture missed");
	AST_TOGGLE: assert property (ce && mode == MODE_TOGGLE && mode_prev_r == mode &&
		compare_match |=> cmp_out_r != $past(cmp_out_r)) else $error("toggle missed");

	COV_HALF: cover property (ce && pwm_mode && cfg == CFG_HALF ##1 oe_second_r);
	COV_SPECIAL: cover property (ce && special_hit && adc_enabled ##1 adc_start_r);
	COV_CAP4: cover property (ce && mode == MODE_CAP_4 && cap_hit);
	COV_IRQ: cover property (irq);
endmodule : ccpm_unit
`default_nettype wire

// *** ccpm_unit_bench.sv ***
`default_nettype none
module ccpm_unit_bench
	import ccpm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk;
	logic        rst;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cap_pin;
	logic [15:0] timer_value;
	logic [9:0]  pwm_count;
	logic        compare_match;
	logic        adc_enabled;
	logic        timer_reset;
	logic        adc_start;
	logic        out_first;
	logic        oe_first;
	logic        out_second;
	logic        oe_second;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	int          error_cnt;
	int          checks;

	ccpm_unit #(.TMR_W(16)) ccpm_unit_inst (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cap_pin, .timer_value, .pwm_count,
		.compare_match, .adc_enabled, .timer_reset, .adc_start, .out_first, .oe_first,
		.out_second, .oe_second, .irq);

	////////////////////////////////////////////////////////////////////////////////
	// Free-running clock at 10 MHz.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Every comparison goes through here so the totals stay honest.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer; the master never assumes a wait count, so it polls pready.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// Only the watchdog ends a wait; zero wait states are expected.
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		chk(32'(n), 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Sampling 1 ns after the edge keeps results away from the update race.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic pulse;
		@(posedge clk);
		compare_match <= 1'b1;
		@(posedge clk);
		compare_match <= 1'b0;
		#1;
	endtask : pulse

	task automatic wrap_up;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog: the sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end

	// Main sequence of register accesses and pin stimulus.
	initial begin
		{rst, ce} = 2'b11;
		{psel, penable, pwrite, cap_pin, compare_match, adc_enabled} = 6'h0;
		{paddr, pwdata, timer_value, pwm_count} = '0;
		error_cnt = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, OFS_CTRL, 32'ha5);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'ha5);
		apb(1'b0, 8'h18, 32'h0);
		chk(32'(err), 32'h1);
		// Unit off: a match must leave every output quiet.
		apb(1'b1, OFS_CTRL, 32'h0);
		apb(1'b1, OFS_IEN, 32'h3);
		pulse();
		chk(32'({timer_reset, oe_first, oe_second, irq}), 32'h0);
		adc_enabled <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h0b);
		tick(2);
		pulse();
		chk(32'({timer_reset, adc_start}), 32'h3);
		tick(1);
		chk(32'({timer_reset, adc_start}), 32'h0);
		apb(1'b0, OFS_STAT, 32'h0);
		chk(rd, 32'h3);
		chk(32'(irq), 32'h1);
		apb(1'b1, OFS_CLR, 32'h3);
		tick(1);
		chk(32'(irq), 32'h0);
		adc_enabled <= 1'b0;
		pulse();
		chk(32'({timer_reset, adc_start}), 32'h2);
		apb(1'b1, OFS_IEN, 32'h0);
		tick(1);
		chk(32'(irq), 32'h0);
		apb(1'b1, OFS_CLR, 32'h3);
		// Toggle compare: starts low, flips once per match.
		apb(1'b1, OFS_CTRL, 32'h02);
		tick(3);
		chk(32'({oe_first, out_first}), 32'h2);
		pulse();
		tick(2);
		chk(32'(out_first), 32'h1);
		// Compare clear: the pin starts high, a match drives it low, no trigger.
		apb(1'b1, OFS_CTRL, 32'h09);
		tick(3);
		chk(32'({oe_first, out_first}), 32'h3);
		pulse();
		chk(32'({out_first, timer_reset}), 32'h0);
		// Capture edges; the opposite edge must not overwrite the value.
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, OFS_CTRL, 32'h0);
			cap_pin <= i[0];
			tick(6);
			apb(1'b1, OFS_CTRL, 32'h5 - 32'(i));
			tick(3);
			apb(1'b1, OFS_CLR, 32'h3);
			timer_value <= 16'h1234 + 16'(i);
			cap_pin <= ~i[0];
			tick(6);
			timer_value <= 16'h5555;
			cap_pin <= i[0];
			tick(6);
			apb(1'b0, OFS_CAPT, 32'h0);
			chk(rd, 32'h1234 + 32'(i));
			apb(1'b0, OFS_STAT, 32'h0);
			chk(rd, 32'h1);
		end
		// Every fourth rising edge captures; the first three only count.
		apb(1'b1, OFS_CTRL, 32'h6);
		cap_pin <= 1'b0;
		tick(6);
		apb(1'b1, OFS_CLR, 32'h3);
		for (int j = 0; j < 4; j++) begin
			timer_value <= 16'(j);
			cap_pin <= 1'b1;
			tick(6);
			cap_pin <= 1'b0;
			tick(6);
			apb(1'b0, OFS_STAT, 32'h0);
			chk(rd, 32'(j == 3));
		end
		apb(1'b0, OFS_CAPT, 32'h0);
		chk(rd, 32'h3);
		// PWM duty is {duty high, low bits} = 6.
		apb(1'b1, OFS_DUTYH, 32'h1);
		pwm_count <= 10'd5;
		apb(1'b1, OFS_CTRL, 32'h2c);
		tick(3);
		chk(32'({oe_first, out_first, oe_second}), 32'h6);
		pwm_count <= 10'd6;
		tick(3);
		chk(32'(out_first), 32'h0);
		apb(1'b1, OFS_CTRL, 32'hac);
		tick(3);
		chk(32'({oe_first, out_first, oe_second, out_second}), 32'hb);
		pwm_count <= 10'd5;
		apb(1'b1, OFS_CTRL, 32'hae);
		tick(3);
		chk(32'({out_first, out_second}), 32'h0);
		apb(1'b1, OFS_CTRL, 32'h88);
		tick(3);
		chk(32'({oe_first, oe_second}), 32'h2);
		// A reset in mid-run must clear the control register and free the pins.
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		chk(32'({oe_first, oe_second}), 32'h0);
		wrap_up();
	end
endmodule : ccpm_unit_bench
`default_nettype wire
